// >>> dcf_pkg.sv
// dual-clock fifo package: geometry, register map, field positions, reset values, carriers
// assumes a single system clock; the fifo pins are sampled on it
package dcf_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int DEPTH     = 256;
	localparam int AW        = 8;
	localparam int PW        = 9;
	localparam int DW        = 18;
	localparam int OW        = 12;
	localparam int CW        = 10;
	localparam logic [CW-1:0] DEPTH_C = 10'h0100;
	localparam logic [CW-1:0] HALF_C  = 10'h0081;

	// ----------------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_STATUS = 12'h0000;
	localparam logic [11:0] ADDR_OFFSET = 12'h0004;
	localparam logic [11:0] ADDR_CONFIG = 12'h0008;
	localparam int OFS_FULL_LSB  = 16;
	localparam int ST_FLAGS_LSB  = 0;
	localparam int ST_RCNT_LSB   = 8;
	localparam int ST_WCNT_LSB   = 20;
	localparam logic [OW-1:0] OFFSET_RST = 12'h001F;
	localparam logic [DW-1:0] DOUT_RST   = 18'h0_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DCF_BUF_SINGLE = 2'b00,
		DCF_BUF_DOUBLE = 2'b01,
		DCF_BUF_FIRST_WORD_FALLTHROUGH   = 2'b11
	} dcf_buf_mode_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dcf_apb_req_type;

	typedef struct packed {
		logic          wr_en_n;
		logic          offset_load_sel_n;
		logic [DW-1:0] write_data_in;
	} dcf_wr_port_type;

endpackage : dcf_pkg

// >>> dcf_fifo.sv
// dual-clock 256x18 fifo with reset-time flag configuration and apb status/offset access
// assumes write and read clock pins are synchronous inputs sampled on pclk (pclk much faster)
//
// Operation
// - while master reset is low, latch first-load and both chain-in straps into configuration
// - first-load 0 gives asynchronous partial flags, 1 gives synchronous partial flags
// - read-chain 0, write-chain 1 gives fallthrough, triple output-ready, double input-ready
// - read-chain 1, write-chain 0 double empty/full; equal chains single empty/full
// - each extra buffering stage delays the boundary flag by one clock
// - buffering affects only empty/ready and full/ready, never partial or half flags
// - standard thresholds: empty 0, almost-empty <=n, half >=D/2+1, almost-full >=D-m
// - fallthrough thresholds shifted by one word, input-ready high at D+1 words
// - empty offset resets to 31 for this depth
// - full offset resets to 31 for this depth
// - master reset returns read and write pointers to location zero
// - reset drives half-full and almost-full high, almost-empty low, full high in standard mode, input-ready low in fallthrough
// - reset drives empty low in standard mode, output-ready high in fallthrough
// - reset clears output data and restores both offsets to defaults
// - write enable low and not full stores the word at the next location
// - write enable is ignored while the buffer is full
// - full/input-ready changes only on write-clock edges and clears after a read
// - write and read clocks may be asynchronous or the same
// - written and stored words are 18 bits wide
// - read data is driven on read-clock edges while output enable is low
// - read enable low and not empty loads the next word; ignored when empty
// - empty/output-ready changes only on read-clock edges
// - fallthrough presents the first word without a read enable
// - load and write enable low write empty then full offset alternately
`timescale 1ns/10ps
module dcf_fifo (
	// system
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire dcf_pkg::dcf_apb_req_type apb_req,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// reset and configuration straps
	input  wire logic                   master_reset_n,
	input  wire logic                   first_load_sel_n,
	input  wire logic                   read_chain_in_n,
	input  wire logic                   write_chain_in_n,
	// write port
	input  wire logic                   wclk_in,
	input  wire dcf_pkg::dcf_wr_port_type wr_port,
	// read port
	input  wire logic                   rclk_in,
	input  wire logic                   rd_en_n,
	input  wire logic                   out_en_n,
	output logic [dcf_pkg::DW-1:0]      read_data_out,
	output logic                        read_data_oe_n,
	// flags
	output logic                        empty_flag_n,
	output logic                        full_flag_n,
	output logic                        almost_empty_n,
	output logic                        almost_full_n,
	output logic                        half_full_n
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [dcf_pkg::PW-1:0] gray2bin(input logic [dcf_pkg::PW-1:0] g);
		logic [dcf_pkg::PW-1:0] b;
		b = g;
		// each lower bit folds in the bits above it; the top bit passes through
		for (int i = dcf_pkg::PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction : gray2bin

	function automatic logic [dcf_pkg::PW-1:0] bin2gray(input logic [dcf_pkg::PW-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	// words held including the fallthrough output register
	function automatic logic [dcf_pkg::CW-1:0] occupancy(input logic [dcf_pkg::PW-1:0] wp,
		input logic [dcf_pkg::PW-1:0] rp, input logic ov);
		logic [dcf_pkg::PW-1:0] d;
		d = wp - rp;
		return {1'b0, d} + {{(dcf_pkg::CW-1){1'b0}}, ov};
	endfunction : occupancy

	// ----------------------------------------------------------------
	// storage and state
	// ----------------------------------------------------------------
	logic [dcf_pkg::DW-1:0]  mem [dcf_pkg::DEPTH];
	logic                    wclk_prev_ff;
	logic                    rclk_prev_ff;
	logic [dcf_pkg::PW-1:0]  wptr_ff;
	logic [dcf_pkg::PW-1:0]  rptr_ff;
	logic [dcf_pkg::PW-1:0]  wgray_ff;
	logic [dcf_pkg::PW-1:0]  rgray_ff;
	logic [dcf_pkg::PW-1:0]  wg_s1_ff;
	logic [dcf_pkg::PW-1:0]  wg_s2_ff;
	logic [dcf_pkg::PW-1:0]  rg_s1_ff;
	logic [dcf_pkg::PW-1:0]  rg_s2_ff;
	logic                    ov_ff;
	logic                    ov_s1_ff;
	logic                    ov_s2_ff;
	logic                    sync_flags_ff;
	dcf_pkg::dcf_buf_mode_type buf_mode_ff;
	logic [dcf_pkg::OW-1:0]  empty_ofs_ff;
	logic [dcf_pkg::OW-1:0]  full_ofs_ff;
	logic                    ofs_sel_full_ff;
	logic [1:0]              ef_pipe_ff;
	logic                    ff_pipe_ff;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic                   w_edge   = wclk_in & ~wclk_prev_ff;
	wire logic                   r_edge   = rclk_in & ~rclk_prev_ff;
	wire logic                   mrst     = ~master_reset_n;
	wire logic                   fw       = (buf_mode_ff == dcf_pkg::DCF_BUF_FIRST_WORD_FALLTHROUGH);
	wire logic                   dbl      = (buf_mode_ff == dcf_pkg::DCF_BUF_DOUBLE);
	wire logic [dcf_pkg::PW-1:0] wsync_b  = gray2bin(wg_s2_ff);
	wire logic [dcf_pkg::PW-1:0] rsync_b  = gray2bin(rg_s2_ff);
	wire logic [dcf_pkg::CW-1:0] r_cnt    = occupancy(wsync_b, rptr_ff, ov_ff);
	wire logic [dcf_pkg::CW-1:0] w_cnt    = occupancy(wptr_ff, rsync_b, ov_s2_ff);
	wire logic                   r_mem_empty = (wsync_b == rptr_ff);
	wire logic                   w_mem_full  = ((wptr_ff - rsync_b) == dcf_pkg::PW'(dcf_pkg::DEPTH));
	wire logic                   w_full   = w_mem_full & (~fw | ov_s2_ff);
	wire logic                   wr_go    = w_edge & ~mrst & ~wr_port.wr_en_n
		& wr_port.offset_load_sel_n & ~w_mem_full;
	wire logic                   ld_go    = w_edge & ~mrst & ~wr_port.wr_en_n
		& ~wr_port.offset_load_sel_n;
	wire logic                   std_rd   = ~fw & ~rd_en_n & ~r_mem_empty;
	wire logic                   fw_load  = fw & ~r_mem_empty & (~ov_ff | ~rd_en_n);
	wire logic                   fw_drop  = fw & ov_ff & ~rd_en_n & r_mem_empty;
	wire logic                   rd_go    = r_edge & ~mrst & (std_rd | fw_load);
	wire logic                   ef_raw   = fw ? ~ov_ff : ~r_mem_empty;
	wire logic                   ff_raw   = fw ? w_full : ~w_full;
	wire logic                   ef_sel   = fw ? ef_pipe_ff[1] : (dbl ? ef_pipe_ff[0] : ef_raw);
	wire logic                   ff_sel   = (fw | dbl) ? ff_pipe_ff : ff_raw;
	wire logic [dcf_pkg::CW:0]   ae_lim   = {1'b0, empty_ofs_ff[dcf_pkg::CW-1:0]}
		+ {{dcf_pkg::CW{1'b0}}, fw};
	wire logic [dcf_pkg::CW:0]   af_lim   = {1'b0, dcf_pkg::DEPTH_C}
		- {1'b0, full_ofs_ff[dcf_pkg::CW-1:0]} + {{dcf_pkg::CW{1'b0}}, fw};
	wire logic [dcf_pkg::CW:0]   hf_lim   = {1'b0, dcf_pkg::HALF_C} + {{dcf_pkg::CW{1'b0}}, fw};
	wire logic                   ae_low   = ({1'b0, r_cnt} <= ae_lim);
	wire logic                   af_low   = ({1'b0, w_cnt} >= af_lim);
	wire logic                   hf_low   = ({1'b0, w_cnt} >= hf_lim);
	wire logic                   ae_upd   = sync_flags_ff ? r_edge : (r_edge | w_edge);
	wire logic                   af_upd   = sync_flags_ff ? w_edge : (r_edge | w_edge);

	// ----------------------------------------------------------------
	// clock pin edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wclk_prev_ff <= 1'b0;
			rclk_prev_ff <= 1'b0;
		end else begin
			wclk_prev_ff <= wclk_in;
			rclk_prev_ff <= rclk_in;
		end
	end

	// ----------------------------------------------------------------
	// configuration straps
	// ----------------------------------------------------------------
	wire dcf_pkg::dcf_buf_mode_type strap_mode =
		(~read_chain_in_n & write_chain_in_n) ? dcf_pkg::DCF_BUF_FIRST_WORD_FALLTHROUGH :
		(read_chain_in_n & ~write_chain_in_n) ? dcf_pkg::DCF_BUF_DOUBLE :
		dcf_pkg::DCF_BUF_SINGLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_flags_ff <= 1'b0;
			buf_mode_ff   <= dcf_pkg::DCF_BUF_SINGLE;
		end else if (mrst) begin
			sync_flags_ff <= first_load_sel_n;
			buf_mode_ff   <= strap_mode;
		end
	end

	// ----------------------------------------------------------------
	// write side
	// ----------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (wr_go) begin
			mem[wptr_ff[dcf_pkg::AW-1:0]] <= wr_port.write_data_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_ff  <= '0;
			wgray_ff <= '0;
		end else if (mrst) begin
			wptr_ff  <= '0;
			wgray_ff <= '0;
		end else if (wr_go) begin
			wptr_ff  <= wptr_ff + 1'b1;
			wgray_ff <= bin2gray(wptr_ff + 1'b1);
		end
	end

	// ----------------------------------------------------------------
	// cross-side synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wg_s1_ff <= '0;
			wg_s2_ff <= '0;
			rg_s1_ff <= '0;
			rg_s2_ff <= '0;
			ov_s1_ff <= 1'b0;
			ov_s2_ff <= 1'b0;
		end else begin
			wg_s1_ff <= wgray_ff;
			wg_s2_ff <= wg_s1_ff;
			rg_s1_ff <= rgray_ff;
			rg_s2_ff <= rg_s1_ff;
			ov_s1_ff <= ov_ff;
			ov_s2_ff <= ov_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// read side
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rptr_ff  <= '0;
			rgray_ff <= '0;
			ov_ff    <= 1'b0;
		end else if (mrst) begin
			rptr_ff  <= '0;
			rgray_ff <= '0;
			ov_ff    <= 1'b0;
		end else if (rd_go) begin
			rptr_ff  <= rptr_ff + 1'b1;
			rgray_ff <= bin2gray(rptr_ff + 1'b1);
			ov_ff    <= fw;
		end else if (r_edge & fw_drop) begin
			ov_ff    <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_data_out  <= dcf_pkg::DOUT_RST;
			read_data_oe_n <= 1'b1;
		end else begin
			read_data_oe_n <= out_en_n;
			if (mrst) begin
				read_data_out <= dcf_pkg::DOUT_RST;
			end else if (rd_go) begin
				read_data_out <= mem[rptr_ff[dcf_pkg::AW-1:0]];
			end
		end
	end

	// ----------------------------------------------------------------
	// offset registers: pin load sequence and apb write
	// ----------------------------------------------------------------
	wire logic apb_fire = apb_req.psel & apb_req.penable & pready;
	wire logic apb_ofs  = apb_fire & apb_req.pwrite & (apb_req.paddr == dcf_pkg::ADDR_OFFSET);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			empty_ofs_ff    <= dcf_pkg::OFFSET_RST;
			full_ofs_ff     <= dcf_pkg::OFFSET_RST;
			ofs_sel_full_ff <= 1'b0;
		end else if (mrst) begin
			empty_ofs_ff    <= dcf_pkg::OFFSET_RST;
			full_ofs_ff     <= dcf_pkg::OFFSET_RST;
			ofs_sel_full_ff <= 1'b0;
		end else if (ld_go) begin
			ofs_sel_full_ff <= ~ofs_sel_full_ff;
			if (ofs_sel_full_ff) begin
				full_ofs_ff  <= wr_port.write_data_in[dcf_pkg::OW-1:0];
			end else begin
				empty_ofs_ff <= wr_port.write_data_in[dcf_pkg::OW-1:0];
			end
		end else if (apb_ofs) begin
			empty_ofs_ff <= apb_req.pwdata[dcf_pkg::OW-1:0];
			full_ofs_ff  <= apb_req.pwdata[dcf_pkg::OFS_FULL_LSB +: dcf_pkg::OW];
		end
	end

	// ----------------------------------------------------------------
	// boundary flags: buffering pipelines
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ef_pipe_ff   <= '0;
			empty_flag_n <= 1'b0;
		end else if (mrst) begin
			ef_pipe_ff   <= {2{fw}};
			empty_flag_n <= fw;
		end else if (r_edge) begin
			ef_pipe_ff   <= {ef_pipe_ff[0], ef_raw};
			empty_flag_n <= ef_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ff_pipe_ff  <= 1'b1;
			full_flag_n <= 1'b1;
		end else if (mrst) begin
			ff_pipe_ff  <= ~fw;
			full_flag_n <= ~fw;
		end else if (w_edge) begin
			ff_pipe_ff  <= ff_raw;
			full_flag_n <= ff_sel;
		end
	end

	// ----------------------------------------------------------------
	// partial and half flags, never buffered
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			almost_empty_n <= 1'b0;
			almost_full_n  <= 1'b1;
			half_full_n    <= 1'b1;
		end else if (mrst) begin
			almost_empty_n <= 1'b0;
			almost_full_n  <= 1'b1;
			half_full_n    <= 1'b1;
		end else begin
			if (ae_upd) begin
				almost_empty_n <= ~ae_low;
			end
			if (af_upd) begin
				almost_full_n  <= ~af_low;
			end
			if (r_edge | w_edge) begin
				half_full_n    <= ~hf_low;
			end
		end
	end

	// ----------------------------------------------------------------
	// apb slave: one wait state, unmapped addresses answer with pslverr
	// ----------------------------------------------------------------
	wire logic        hit_st  = (apb_req.paddr == dcf_pkg::ADDR_STATUS);
	wire logic        hit_of  = (apb_req.paddr == dcf_pkg::ADDR_OFFSET);
	wire logic        hit_cf  = (apb_req.paddr == dcf_pkg::ADDR_CONFIG);
	wire logic [31:0] st_word = ({27'h000_0000, empty_flag_n, full_flag_n, almost_empty_n,
		almost_full_n, half_full_n} << dcf_pkg::ST_FLAGS_LSB)
		| ({22'h00_0000, r_cnt} << dcf_pkg::ST_RCNT_LSB)
		| ({22'h00_0000, w_cnt} << dcf_pkg::ST_WCNT_LSB);
	wire logic [31:0] of_word = ({20'h0_0000, full_ofs_ff} << dcf_pkg::OFS_FULL_LSB)
		| {20'h0_0000, empty_ofs_ff};
	wire logic [31:0] cf_word = {29'h0000_0000, sync_flags_ff, buf_mode_ff};
	wire logic [31:0] rd_word = hit_st ? st_word : (hit_of ? of_word : (hit_cf ? cf_word : '0));
	wire logic        access  = apb_req.psel & apb_req.penable & ~pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access;
			pslverr <= access & ~(hit_st | hit_of | hit_cf) ;
			prdata  <= (access & ~apb_req.pwrite) ? rd_word : 32'h0000_0000;
		end
	end

endmodule : dcf_fifo

// >>> dcf_fifo_monitor.sv
// dcf fifo checker: timing relations seen at the top-level ports
// assumes it is bound onto dcf_fifo and that every pin is sampled on pclk
`timescale 1ns/10ps
module dcf_fifo_monitor (
	// system
	input wire logic                     pclk,
	input wire logic                     presetn,
	// apb
	input wire dcf_pkg::dcf_apb_req_type apb_req,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// fifo pins
	input wire logic                     master_reset_n,
	input wire logic                     wclk_in,
	input wire logic                     rclk_in,
	input wire logic [dcf_pkg::DW-1:0]   read_data_out,
	input wire logic                     empty_flag_n,
	input wire logic                     full_flag_n,
	input wire logic                     almost_empty_n,
	input wire logic                     almost_full_n,
	input wire logic                     half_full_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [1:0] run_ff;
	logic [1:0] nxt_run_ff;
	wire        access = apb_req.psel && apb_req.penable && !pready;
	// flags may settle just after device reset, so only watch a run of three edges
	wire        settled = master_reset_n && (run_ff == 2'h3);

	assign nxt_run_ff = !master_reset_n ? 2'h0 : (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_ff <= 2'h0;
		else
			run_ff <= nxt_run_ff;
	end

	apb_answer_a: assert property (access |=> pready)
		else $error("apb access not answered after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	error_ready_a: assert property (pslverr |-> pready && prdata == '0)
		else $error("pslverr without pready or with data");
	rdata_idle_a: assert property (!pready |-> prdata == '0)
		else $error("prdata nonzero outside an answer");
	empty_rclk_a: assert property (settled && $changed(empty_flag_n) |-> $past(rclk_in) && !$past(rclk_in, 2))
		else $error("empty flag moved without a read clock edge");
	full_wclk_a: assert property (settled && $changed(full_flag_n) |-> $past(wclk_in) && !$past(wclk_in, 2))
		else $error("full flag moved without a write clock edge");
	rdata_rclk_a: assert property (settled && $changed(read_data_out) |-> $past(rclk_in) && !$past(rclk_in, 2))
		else $error("output data moved without a read clock edge");
	reset_flags_a: assert property (!master_reset_n |=> !almost_empty_n && almost_full_n && half_full_n && read_data_out == '0)
		else $error("device reset values wrong");
endmodule : dcf_fifo_monitor

bind dcf_fifo dcf_fifo_monitor i_dcf_fifo_monitor (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .master_reset_n(master_reset_n), .wclk_in(wclk_in), .rclk_in(rclk_in),
	.read_data_out(read_data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
	.almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .half_full_n(half_full_n)
);

// >>> dcf_host.sv
// writer and reader host: pulses the fifo write and read clock pins on request
// assumes pins change right after a pclk rising edge; clocks stand still between pulses
`timescale 1ns/10ps
module dcf_host (
	// system
	input  wire logic                 pclk,
	// write side
	output logic                      wclk_in,
	output dcf_pkg::dcf_wr_port_type  wr_port,
	// read side
	output logic                      rclk_in,
	output logic                      rd_en_n
);
	initial begin
		wclk_in = 1'b0;
		rclk_in = 1'b0;
		rd_en_n = 1'b1;
		wr_port = '{1'b1, 1'b1, 18'h0_0000};
	end

	// one write clock pulse; released data shows the inverse of the last word
	task automatic wr_edge(input logic en_n, input logic load_n, input logic [17:0] d);
		@(posedge pclk);
		wr_port <= '{en_n, load_n, d};
		wclk_in <= 1'b1;
		@(posedge pclk);
		wclk_in <= 1'b0;
		wr_port <= '{1'b1, 1'b1, ~d};
		@(posedge pclk);
	endtask : wr_edge

	task automatic rd_edge(input logic en_n);
		@(posedge pclk);
		rd_en_n <= en_n;
		rclk_in <= 1'b1;
		@(posedge pclk);
		rclk_in <= 1'b0;
		rd_en_n <= 1'b1;
		@(posedge pclk);
	endtask : rd_edge
endmodule : dcf_host

// >>> dcf_fifo_tb.sv
// dcf fifo testbench: apb access, fill and drain in three modes, straps, flag delay
// assumes dcf_pkg, dcf_fifo, dcf_host and the bound checker are compiled first
`timescale 1ns/10ps
module dcf_fifo_tb;
	logic                     pclk;
	logic                     presetn;
	dcf_pkg::dcf_apb_req_type apb_req;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     master_reset_n;
	logic [2:0]               straps;
	logic                     out_en_n;
	logic                     wclk_in;
	logic                     rclk_in;
	logic                     rd_en_n;
	dcf_pkg::dcf_wr_port_type wr_port;
	logic [17:0]              read_data_out;
	logic                     read_data_oe_n;
	logic [4:0]               flags;
	int                       bad_count = 0;
	int                       checks = 0;

	dcf_fifo i_dcf_fifo (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_reset_n(master_reset_n), .first_load_sel_n(straps[2]),
		.read_chain_in_n(straps[1]), .write_chain_in_n(straps[0]), .wclk_in(wclk_in),
		.wr_port(wr_port), .rclk_in(rclk_in), .rd_en_n(rd_en_n), .out_en_n(out_en_n),
		.read_data_out(read_data_out), .read_data_oe_n(read_data_oe_n),
		.empty_flag_n(flags[4]), .full_flag_n(flags[3]), .almost_empty_n(flags[2]),
		.almost_full_n(flags[1]), .half_full_n(flags[0])
	);
	dcf_host i_dcf_host (.pclk(pclk), .wclk_in(wclk_in), .wr_port(wr_port),
		.rclk_in(rclk_in), .rd_en_n(rd_en_n));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
		if (n >= 20) begin
			bad_count++;
			give_verdict();
		end
	endtask : apb_xfer

	// device reset with straps held; always done before any write
	task automatic mreset(input logic [2:0] s);
		@(posedge pclk);
		master_reset_n <= 1'b0;
		straps <= s;
		repeat (3) @(posedge pclk);
		master_reset_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : mreset

	task automatic settle();
		fork
			repeat (6) i_dcf_host.rd_edge(1'b1);
			repeat (6) i_dcf_host.wr_edge(1'b1, 1'b1, 18'h0_0000);
		join
	endtask : settle

	function automatic logic [17:0] pat(input int k);
		return {k[8:0], ~k[8:0]};
	endfunction : pat

	function automatic logic [4:0] exp_flags(input int c, input bit ft, input int n, input int m);
		if (ft)
			return {c == 0, c == 257, c > n + 1, c < 257 - m, c < 130};
		return {c != 0, c != 256, c > n, c < 256 - m, c < 129};
	endfunction : exp_flags

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_apb();
		logic [31:0] rd;
		logic        err;
		apb_xfer(1'b1, dcf_pkg::ADDR_OFFSET, 32'h0014_0009, rd, err);
		apb_xfer(1'b0, dcf_pkg::ADDR_OFFSET, '0, rd, err);
		chk("offset readback", 32'h0014_0009, rd);
		apb_xfer(1'b1, dcf_pkg::ADDR_CONFIG, 32'hFFFF_FFFF, rd, err);
		chk("read-only write error", '0, 32'(err));
		apb_xfer(1'b0, 12'h00C, '0, rd, err);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		chk("unmapped data", '0, rd);
		out_en_n <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("output off", 32'h0000_0001, 32'(read_data_oe_n));
		out_en_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("output on", '0, 32'(read_data_oe_n));
		$display("apb test done");
	endtask : t_apb

	task automatic t_stream(input logic [2:0] s, input bit ft, input int n, input int m);
		int          cap;
		logic [31:0] rd;
		logic        err;
		cap = ft ? 257 : 256;
		mreset(s);
		if (n != 31) begin
			i_dcf_host.wr_edge(1'b0, 1'b0, 18'(n));
			i_dcf_host.wr_edge(1'b0, 1'b0, 18'(m));
			apb_xfer(1'b0, dcf_pkg::ADDR_OFFSET, '0, rd, err);
			chk("pin offsets", {4'h0, 12'(m), 4'h0, 12'(n)}, rd);
		end
		for (int k = 1; k <= cap + 1; k++) begin
			i_dcf_host.wr_edge(1'b0, 1'b1, pat(k));
			settle();
			chk("flags on fill", 32'(exp_flags(k > cap ? cap : k, ft, n, m)), 32'(flags));
		end
		apb_xfer(1'b0, dcf_pkg::ADDR_STATUS, '0, rd, err);
		chk("count when full", 32'(cap), 32'(rd[29:20]));
		for (int k = 1; k <= cap; k++) begin
			if (ft)
				chk("head word", 32'(pat(k)), 32'(read_data_out));
			i_dcf_host.rd_edge(1'b0);
			if (!ft)
				chk("read word", 32'(pat(k)), 32'(read_data_out));
			settle();
			chk("flags on drain", 32'(exp_flags(cap - k, ft, n, m)), 32'(flags));
		end
		i_dcf_host.rd_edge(1'b0);
		chk("read when empty", 32'(pat(cap)), 32'(read_data_out));
		$display("stream test done for straps %b", s);
	endtask : t_stream

	task automatic t_config();
		logic [31:0] rd;
		logic        err;
		logic [1:0]  mode;
		for (int i = 0; i < 8; i++) begin
			mreset(3'(i));
			mode = (i[1:0] == 2'b01) ? 2'b11 : (i[1:0] == 2'b10) ? 2'b01 : 2'b00;
			apb_xfer(1'b0, dcf_pkg::ADDR_CONFIG, '0, rd, err);
			chk("config", {29'h0, i[2], mode}, rd);
			chk("reset flags", {27'h0, mode == 2'b11, mode != 2'b11, 3'b011}, 32'(flags));
		end
		apb_xfer(1'b0, dcf_pkg::ADDR_OFFSET, '0, rd, err);
		chk("default offsets", 32'h001F_001F, rd);
		$display("config test done");
	endtask : t_config

	task automatic t_latency();
		int          lat [2];
		logic [31:0] rd;
		logic        err;
		for (int i = 0; i < 2; i++) begin
			mreset(i ? 3'b010 : 3'b000);
			i_dcf_host.wr_edge(1'b0, 1'b1, pat(7));
			lat[i] = 0;
			while (flags[4] !== 1'b1 && lat[i] < 12) begin
				i_dcf_host.rd_edge(1'b1);
				lat[i]++;
			end
			if (lat[i] >= 12) begin
				bad_count++;
				$display("empty flag wait limit reached");
				give_verdict();
			end
		end
		chk("extra stage delay", 32'(lat[0] + 1), 32'(lat[1]));
		mreset(3'b000);
		apb_xfer(1'b0, dcf_pkg::ADDR_STATUS, '0, rd, err);
		chk("counts after reset", '0, 32'({rd[29:20], rd[17:8]}));
		$display("latency test done");
	endtask : t_latency

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		master_reset_n = 1'b0;
		straps = 3'b000;
		out_en_n = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// offsets are held at their defaults while the device reset is low
		mreset(3'b000);
		t_apb();
		t_stream(3'b000, 1'b0, 31, 31);
		t_stream(3'b110, 1'b0, 31, 31);
		t_stream(3'b101, 1'b1, 5, 10);
		t_config();
		t_latency();
		give_verdict();
	end

	initial begin
		repeat (90000) @(posedge pclk);
		bad_count++;
		$display("run limit reached");
		give_verdict();
	end
endmodule : dcf_fifo_tb
